// ---- hw/ecs_pkg.sv ----
// What this block does
// - latch ten data bits each active edge
// - edge select high rising, low falling
// - output enable low floats both outputs
// - power down stops, floats, overrides all but a request held until waking, served after waking
// - alignment request sends at least 1024 symbols
// - alignment continues until request released
// - two alignment requests are ORed together
// - each frame carries two embedded clock bits
package ecs_pkg;
  localparam int DATA_BITS = 10;            // parallel word width
  localparam int FRAME_BITS = 12;           // data plus two clock bits
  localparam int SLOT_BITS = 4;             // width of the bit slot count
  localparam int ALIGN_MIN = 1024;          // least alignment symbols
  localparam int ALIGN_CNT_BITS = 11;       // holds ALIGN_MIN
  localparam int TRANSMIT_CLOCK_MIN_MHZ = 16;         // slowest transmit clock
  localparam int TRANSMIT_CLOCK_MAX_MHZ = 40;         // fastest transmit clock
  localparam int REF_MHZ = 250;             // bit slot clock rate
  // frame layout: start bit high, data msb first, stop bit low
  localparam logic START_BIT = 1'b1;
  localparam logic STOP_BIT = 1'b0;
  localparam logic [FRAME_BITS-1:0] ALIGN_SYMBOL = 12'hfc0;
  localparam logic [FRAME_BITS-1:0] IDLE_FRAME = 12'h000;
  localparam logic [SLOT_BITS-1:0] LAST_SLOT = 4'hb;
  localparam logic [SLOT_BITS-1:0] FIRST_SLOT = 4'h0;
  localparam logic [ALIGN_CNT_BITS-1:0] ALIGN_DONE = 11'h400;
  localparam logic [ALIGN_CNT_BITS-1:0] ALIGN_ZERO = 11'h000;
  localparam logic [DATA_BITS-1:0] WORD_RESET = 10'h000;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b001,  // powered down, line floating
    ST_DATA  = 3'b010,  // sending captured words
    ST_ALIGN = 3'b100   // sending alignment symbols
  } ecs_state_e;
endpackage : ecs_pkg

// ---- hw/ecs_frame_if.sv ----
`timescale 1ns/10ps
// carries frames from the framing logic to the bit shifter
interface ecs_frame_if;
  import ecs_pkg::*;
  logic run;                          // shifter may run
  logic [FRAME_BITS-1:0] frame;       // frame to send next
  logic taken;                        // pulse: frame was loaded
  logic bit_val;                      // current line bit
  modport framer (output run, output frame, input taken, input bit_val);
  modport shifter (input run, input frame, output taken, output bit_val);
endinterface : ecs_frame_if

// ---- hw/ecs_shifter.sv ----
`timescale 1ns/10ps
// shifts one frame out msb first, one bit per clock
module ecs_shifter
  import ecs_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  ecs_frame_if.shifter frm
);
  logic [FRAME_BITS-1:0] shift_ff;  // bits still to send
  logic [SLOT_BITS-1:0] slot_ff;    // current bit slot
  logic taken_ff;                   // load pulse back to framer

  // slot counter wraps every frame; held at slot zero while stopped
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      slot_ff <= FIRST_SLOT;
    end
    else if (!frm.run || slot_ff == LAST_SLOT)
    begin
      slot_ff <= FIRST_SLOT;
    end
    else
    begin
      slot_ff <= slot_ff + 4'h1;
    end
  end

  // load a new frame at the first slot, otherwise shift left
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      shift_ff <= IDLE_FRAME;
      taken_ff <= 1'b0;
    end
    else if (frm.run && slot_ff == FIRST_SLOT)
    begin
      shift_ff <= frm.frame;
      taken_ff <= 1'b1;
    end
    else
    begin
      shift_ff <= {shift_ff[FRAME_BITS-2:0], 1'b0};
      taken_ff <= 1'b0;
    end
  end

  assign frm.taken = taken_ff;
  assign frm.bit_val = shift_ff[FRAME_BITS-1];
endmodule : ecs_shifter

// ---- hw/ecs_serializer.sv ----
`timescale 1ns/10ps
// embedded clock serializer: capture on transmit_clock, send on ref_clk_in
module ecs_serializer
  import ecs_pkg::*;
#(
  parameter int ALIGN_SYMBOLS = ALIGN_MIN  // least symbols per request
)
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic transmit_clock_in,
  input wire logic [ecs_pkg::DATA_BITS-1:0] data_in,
  input wire logic strobe_edge_select_in,
  input wire logic serial_output_enable_in,
  input wire logic power_down_n_in,
  input wire logic align_request_a_in,
  input wire logic align_request_b_in,
  output logic line_p_out,
  output logic line_n_out,
  output logic line_oe_n_out,
  output logic align_active_out,
  output logic pll_running_out
);
  import ecs_pkg::*;

  initial
  begin
    if (ALIGN_SYMBOLS < 1 || ALIGN_SYMBOLS > int'(ALIGN_DONE))
      $error("ALIGN_SYMBOLS out of range");
  end

  localparam logic [ALIGN_CNT_BITS-1:0] ALIGN_LAST =
    ALIGN_CNT_BITS'(ALIGN_SYMBOLS - 1);

  // ---- transmit clock domain ----
  logic sel_s1_ff;                  // edge select, first stage
  logic sel_s2_ff;                  // edge select, settled
  logic [DATA_BITS-1:0] hold_r_ff;  // word caught on rising edge
  logic [DATA_BITS-1:0] hold_f_ff;  // word caught on falling edge
  logic tog_r_ff;                   // flips on each rising capture
  logic tog_f_ff;                   // flips on each falling capture

  // edge select is a pin, settle it before use
  always_ff @(posedge transmit_clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sel_s1_ff <= 1'b1;
      sel_s2_ff <= 1'b1;
    end
    else
    begin
      sel_s1_ff <= strobe_edge_select_in;
      sel_s2_ff <= sel_s1_ff;
    end
  end

  // rising edge capture, used when select is high
  always_ff @(posedge transmit_clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      hold_r_ff <= WORD_RESET;
      tog_r_ff <= 1'b0;
    end
    else if (sel_s2_ff)
    begin
      hold_r_ff <= data_in;
      tog_r_ff <= ~tog_r_ff;
    end
  end

  // falling edge capture, used when select is low
  always_ff @(negedge transmit_clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      hold_f_ff <= WORD_RESET;
      tog_f_ff <= 1'b0;
    end
    else if (!sel_s2_ff)
    begin
      hold_f_ff <= data_in;
      tog_f_ff <= ~tog_f_ff;
    end
  end

  // ---- reference clock domain ----
  // pins and both capture toggles each pass two flops
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync_s1_ff;
  logic [NSYNC-1:0] sync_s2_ff;
  logic [NSYNC-1:0] sync_raw;
  // one toggle per edge, so the live edge is known without the strap
  assign sync_raw = {tog_r_ff, tog_f_ff, power_down_n_in,
                     serial_output_enable_in,
                     align_request_a_in, align_request_b_in};

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sync_s1_ff <= '0;
      sync_s2_ff <= '0;
    end
    else
    begin
      sync_s1_ff <= sync_raw;
      sync_s2_ff <= sync_s1_ff;
    end
  end

  logic tog_r_sync;    // settled rising capture toggle
  logic tog_f_sync;    // settled falling capture toggle
  logic pwr_on;        // settled power_down_n
  logic out_en;        // settled serial_output_enable
  logic align_req;     // either request, settled
  assign tog_r_sync = sync_s2_ff[5];
  assign tog_f_sync = sync_s2_ff[4];
  assign pwr_on = sync_s2_ff[3];
  assign out_en = sync_s2_ff[2];
  assign align_req = sync_s2_ff[1] | sync_s2_ff[0];

  logic seen_r_ff;                  // last rising toggle taken
  logic seen_f_ff;                  // last falling toggle taken
  logic [DATA_BITS-1:0] word_ff;    // newest captured word
  logic pend_ff;                    // request seen, not yet served

  // take the word once the toggle shows it settled; the hold
  // register stopped moving two ref edges earlier. a word not yet
  // framed is replaced by a newer one: the bit clock must run at
  // least twelve times the transmit clock for nothing to be lost
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      seen_r_ff <= 1'b0;
      seen_f_ff <= 1'b0;
      word_ff <= WORD_RESET;
    end
    else
    begin
      seen_r_ff <= tog_r_sync;
      seen_f_ff <= tog_f_sync;
      // whichever toggle moved names the hold register to read
      if (tog_r_sync != seen_r_ff)
        word_ff <= hold_r_ff;
      else if (tog_f_sync != seen_f_ff)
        word_ff <= hold_f_ff;
    end
  end

  ecs_frame_if frm ();

  ecs_state_e state_ff;
  ecs_state_e nxt_state;
  logic [ALIGN_CNT_BITS-1:0] align_cnt_ff;  // symbols sent this run

  // a short request pulse while awake is kept until a frame load can act on it;
  // a new request wins over the sleep clear; in alignment the clear wins
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pend_ff <= 1'b0;
    end
    else if (align_req && state_ff != ST_ALIGN)
    begin
      pend_ff <= 1'b1;
    end
    else if (state_ff == ST_ALIGN || !pwr_on)
    begin
      pend_ff <= 1'b0;
    end
  end

  // state choice at each frame load, sleep entry and exit on any clock;
  // waking always passes through data so every burst starts one frame after its state change
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_SLEEP:
        nxt_state = ST_DATA;
      ST_DATA:
        if (frm.taken && (align_req || pend_ff))
          nxt_state = ST_ALIGN;
      ST_ALIGN:
        // leave only after the minimum and once released
        if (frm.taken && !align_req && align_cnt_ff >= ALIGN_LAST)
          nxt_state = ST_DATA;
      default:
        nxt_state = ST_SLEEP;
    endcase
    if (!pwr_on)
      nxt_state = ST_SLEEP;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_ff <= ST_SLEEP;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // count alignment symbols; saturate so long requests never wrap
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      align_cnt_ff <= ALIGN_ZERO;
    end
    else if (state_ff != ST_ALIGN)
    begin
      align_cnt_ff <= ALIGN_ZERO;
    end
    else if (frm.taken && align_cnt_ff < ALIGN_DONE)
    begin
      align_cnt_ff <= align_cnt_ff + 11'h001;
    end
  end

  logic [FRAME_BITS-1:0] frame_ff;  // frame offered to the shifter

  // build the next frame; refreshed on every clock until the load takes it
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      frame_ff <= IDLE_FRAME;
    end
    else if (nxt_state == ST_ALIGN)
    begin
      frame_ff <= ALIGN_SYMBOL;
    end
    else
    begin
      frame_ff <= {START_BIT, word_ff, STOP_BIT};
    end
  end

  assign frm.run = (state_ff != ST_SLEEP);
  assign frm.frame = frame_ff;

  ecs_shifter u_shifter (
    .ref_clk_in (ref_clk_in),
    .arst_n_in (arst_n_in),
    .frm (frm)
  );

  // line drivers; enable low while driving
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      line_p_out <= 1'b0;
      line_n_out <= 1'b1;
      line_oe_n_out <= 1'b1;
      align_active_out <= 1'b0;
      pll_running_out <= 1'b0;
    end
    else
    begin
      line_p_out <= frm.bit_val;
      line_n_out <= ~frm.bit_val;
      // float when disabled or asleep
      line_oe_n_out <= ~(out_en & pwr_on & (state_ff != ST_SLEEP));
      align_active_out <= (state_ff == ST_ALIGN);
      pll_running_out <= pwr_on;
    end
  end
endmodule : ecs_serializer

// ---- verification/ecs_serializer_chk.sv ----
`timescale 1ns/10ps
// pin level checks of the serializer, bit slot domain only
module ecs_serializer_chk
  import ecs_pkg::*;
#(
  parameter int ALIGN_SYMBOLS = ALIGN_MIN  // least symbols per request
)
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic serial_output_enable_in,
  input wire logic power_down_n_in,
  input wire logic align_request_a_in,
  input wire logic align_request_b_in,
  input wire logic line_p_out,
  input wire logic line_n_out,
  input wire logic line_oe_n_out,
  input wire logic align_active_out,
  input wire logic pll_running_out
);
  logic [15:0] act_cnt_ff;  // cycles of the current alignment burst
  logic [7:0] req_cnt_ff;   // cycles of steady request, saturating
  logic [4:0] run_cnt_ff;   // equal line bits in a row, saturating
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // burst length, so a short burst is caught at its end
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      act_cnt_ff <= 16'h0000;
    else
      act_cnt_ff <= align_active_out ? act_cnt_ff + 16'h0001 : 16'h0000;
  end

  // steady request while awake; sleep restarts the count
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      req_cnt_ff <= 8'h00;
    else if ((align_request_a_in || align_request_b_in) && power_down_n_in)
      req_cnt_ff <= (req_cnt_ff == 8'hff) ? req_cnt_ff : req_cnt_ff + 8'h01;
    else
      req_cnt_ff <= 8'h00;
  end

  // run length of the driven line; a float breaks the run
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      run_cnt_ff <= 5'h00;
    else if (line_oe_n_out || !pll_running_out)
      run_cnt_ff <= 5'h00;
    else if (line_p_out != $past(line_p_out))
      run_cnt_ff <= 5'h01;
    else if (run_cnt_ff != 5'h1f)
      run_cnt_ff <= run_cnt_ff + 5'h01;
  end

  a_float_disabled: assert property (
    (!serial_output_enable_in) [*4] |-> line_oe_n_out)
    else $error("line driven while disabled");
  a_drive_enabled: assert property (
    (serial_output_enable_in && power_down_n_in) [*5] |-> !line_oe_n_out)
    else $error("line floats while enabled");
  a_sleep_float: assert property (
    (!power_down_n_in) [*4] |-> line_oe_n_out && !pll_running_out)
    else $error("sleep did not float the line");
  a_pll_wakes: assert property (
    power_down_n_in [*5] |-> pll_running_out)
    else $error("pll not running while awake");
  a_line_compl: assert property (
    line_n_out != line_p_out)
    else $error("line pair not complementary");
  a_align_min: assert property (
    $fell(align_active_out) && pll_running_out
    |-> act_cnt_ff >= ALIGN_SYMBOLS * FRAME_BITS - 1)
    else $error("alignment burst too short");
  a_align_holds: assert property (
    req_cnt_ff >= 8'h18 && pll_running_out |-> align_active_out)
    else $error("alignment stopped under request");
  a_align_symbol: assert property (
    $rose(line_p_out) && align_active_out && $past(align_active_out, 12)
    |-> line_p_out [*6] ##1 (!line_p_out) [*6])
    else $error("alignment symbol shape wrong");
  a_edge_run: assert property (
    run_cnt_ff <= 5'h0b)
    else $error("no transition within a frame");
endmodule : ecs_serializer_chk

bind ecs_serializer ecs_serializer_chk #(.ALIGN_SYMBOLS(ALIGN_SYMBOLS))
  ecs_serializer_chk_inst (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
  .serial_output_enable_in(serial_output_enable_in),
  .power_down_n_in(power_down_n_in), .align_request_a_in(align_request_a_in),
  .align_request_b_in(align_request_b_in), .line_p_out(line_p_out),
  .line_n_out(line_n_out), .line_oe_n_out(line_oe_n_out),
  .align_active_out(align_active_out), .pll_running_out(pll_running_out));

// ---- verification/ecs_rx_model.sv ----
`timescale 1ns/10ps
// remote deserializer: locks on symbols, decodes frames
module ecs_rx_model
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic line_in,
  input wire logic oe_n_in,
  output logic lock_n_out,
  output logic [9:0] word_out
);
  logic [11:0] sr_ff;   // last twelve line bits
  logic [3:0] ph_ff;    // slot within the frame
  logic [2:0] good_ff;  // symbols seen while unlocked
  logic [2:0] bad_ff;   // bad clock bits in a row
  logic [11:0] nsr;     // window including this bit
  assign nsr = {sr_ff[10:0], line_in};

  // lock tracking; a floated line always drops lock
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lock_n_out <= 1'b1;
      {sr_ff, ph_ff, good_ff, bad_ff} <= '0;
      word_out <= 10'h000;
    end
    else if (oe_n_in)
    begin
      lock_n_out <= 1'b1;
      good_ff <= 3'h0;
      bad_ff <= 3'h0;
    end
    else
    begin
      sr_ff <= nsr;
      ph_ff <= (ph_ff == 4'hb) ? 4'h0 : ph_ff + 4'h1;
      if (lock_n_out && nsr == 12'hfc0)
      begin
        ph_ff <= 4'h0;  // symbol end fixes the frame phase
        good_ff <= good_ff + 3'h1;
        if (good_ff == 3'h3)
          lock_n_out <= 1'b0;
      end
      else if (!lock_n_out && ph_ff == 4'hb)
      begin
        if (nsr[11] && !nsr[0])
        begin
          bad_ff <= 3'h0;
          if (nsr != 12'hfc0)
            word_out <= nsr[10:1];
        end
        else
        begin
          bad_ff <= bad_ff + 3'h1;
          if (bad_ff == 3'h3)
            lock_n_out <= 1'b1;
        end
      end
    end
  end
endmodule : ecs_rx_model

// ---- verification/ecs_serializer_tb_top.sv ----
`timescale 1ns/10ps
module ecs_serializer_tb_top;
  import ecs_pkg::*;
  typedef struct {logic [9:0] word; logic rise;} ecs_row_s;
  localparam int AS = 8;  // short burst keeps the run brief
  logic ref_clk = 0, tx_clk = 0, arst_n = 0;
  logic [9:0] data = 10'h000;
  logic edge_sel = 1, oe = 1, pdn_n = 1, req_a = 0, req_b = 0;
  logic line_p, line_n, line_oe_n, align_act, pll_run, lock_n;
  logic [9:0] rx_word;
  int fails = 0, check_count = 0, i, n;
  ecs_row_s rows [4] = '{'{10'h155, 1}, '{10'h2aa, 0}, '{10'h001, 1},
                          '{10'h3ff, 0}};

  always #2 ref_clk = ~ref_clk;
  // link clock, phase offset from the slot clock
  initial #3 forever #7.5 tx_clk = ~tx_clk;
  // receiver lock flag loops back as a request
  always @(posedge ref_clk) req_a <= lock_n;

  ecs_serializer #(.ALIGN_SYMBOLS(AS)) ecs_serializer_inst (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .transmit_clock_in(tx_clk),
    .data_in(data), .strobe_edge_select_in(edge_sel),
    .serial_output_enable_in(oe), .power_down_n_in(pdn_n),
    .align_request_a_in(req_a), .align_request_b_in(req_b),
    .line_p_out(line_p), .line_n_out(line_n), .line_oe_n_out(line_oe_n),
    .align_active_out(align_act), .pll_running_out(pll_run));
  ecs_rx_model ecs_rx_model_inst (.clk_in(ref_clk), .rst_n_in(arst_n),
    .line_in(line_p), .oe_n_in(line_oe_n), .lock_n_out(lock_n),
    .word_out(rx_word));

  task chk(input string name, input logic [15:0] seen, input logic [15:0] e);
    check_count++;
    if (seen !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h seen %h", name, e, seen);
    end
  endtask : chk

  task end_of_test();
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // hold a word long enough that one frame carries it whole
  task run_row(input ecs_row_s r);
    @(posedge ref_clk);
    data <= r.word;
    edge_sel <= r.rise;
    repeat (80) @(posedge ref_clk);
    chk("rx_word", {6'h00, rx_word}, {6'h00, r.word});
  endtask : run_row

  // bounded wait for the receiver to lock again
  task wait_lock();
    for (i = 0; i < 3000 && lock_n !== 1'b0; i++)
      @(posedge ref_clk);
    chk("lock_n", {15'h0000, lock_n}, 16'h0000);
  endtask : wait_lock

  initial
  begin
    #100us;
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1;
    wait_lock();
    foreach (rows[k])
      run_row(rows[k]);
    // short pulse still yields the full burst
    req_b <= 1;
    repeat (3) @(posedge ref_clk);
    req_b <= 0;
    for (i = 0; i < 40 && align_act !== 1'b1; i++)
      @(posedge ref_clk);
    for (n = 0; align_act === 1'b1 && n < 2000; n++)
      @(posedge ref_clk);
    chk("align_len", 16'(n >= AS * FRAME_BITS), 16'h0001);
    // long request keeps the symbols coming
    req_b <= 1;
    repeat (200) @(posedge ref_clk);
    chk("align_held", {15'h0000, align_act}, 16'h0001);
    req_b <= 0;
    for (i = 0; i < 40 && align_act !== 1'b0; i++)
      @(posedge ref_clk);
    chk("align_end", {15'h0000, align_act}, 16'h0000);
    // disable floats the pair; receiver loses lock
    oe <= 0;
    repeat (20) @(posedge ref_clk);
    chk("oe_n", {15'h0000, line_oe_n}, 16'h0001);
    chk("lost", {15'h0000, lock_n}, 16'h0001);
    oe <= 1;
    wait_lock();
    run_row(rows[2]);
    // sleep wins over enable and requests
    pdn_n <= 0;
    req_b <= 1;
    repeat (8) @(posedge ref_clk);
    chk("sleep_oe_n", {15'h0000, line_oe_n}, 16'h0001);
    chk("sleep_pll", {15'h0000, pll_run}, 16'h0000);
    pdn_n <= 1;
    req_b <= 0;
    wait_lock();
    run_row(rows[3]);
    end_of_test();
  end
endmodule : ecs_serializer_tb_top
